//--- include/hci_consts.svh
`ifndef HCI_CONSTS_SVH
`define HCI_CONSTS_SVH

// register map
`define HCI_ADDR_W          11
`define HCI_DATA_W          8
`define HCI_GPC_ADDR        11'h006
`define HCI_GPC_DIR_LSB     0
`define HCI_GPC_LEVEL_LSB   2
`define HCI_GPC_RESET       8'h00
`define HCI_UNMAPPED_RDATA  8'h00
`define HCI_GPIO_N          2

// timing
`define HCI_CLK_PERIOD_NS   8
`define HCI_RESET_MIN_NS    100
`define HCI_RESET_WAIT_NS   2000000
`define HCI_RESET_WAIT_CYC  ((`HCI_RESET_WAIT_NS + `HCI_CLK_PERIOD_NS - 1) / `HCI_CLK_PERIOD_NS)

// serial frame: read flag, address msb first, then data msb first
`define HCI_SER_HDR_BITS    12
`define HCI_SER_FRAME_BITS  20
`define HCI_SER_CNT_W       5

`endif

//--- include/hci_pkg.sv
package hci_pkg;

  // access sequencer, gray coded along blocked -> idle -> armed -> transfer -> blocked
  typedef enum logic [1:0] {
    HCI_ST_BLOCKED = 2'b00,
    HCI_ST_IDLE    = 2'b01,
    HCI_ST_ARMED   = 2'b11,
    HCI_ST_XFER    = 2'b10
  } hci_state_t;

  typedef enum logic {
    HCI_STYLE_DIR_STROBE = 1'b0,
    HCI_STYLE_RD_WR      = 1'b1
  } hci_style_t;

endpackage

//--- rtl/hci_serial_port.sv
`timescale 1ns/100ps
`include "hci_consts.svh"

module hci_serial_port #(
  parameter int ADDR_W = `HCI_ADDR_W,
  parameter int DATA_W = `HCI_DATA_W
) (
  // clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_resetn,
  // link pins
  input  wire logic              i_enable,
  input  wire logic              i_sclk,
  input  wire logic              i_sdi,
  // register side
  input  wire logic [DATA_W-1:0] i_rdata,
  output logic      [ADDR_W-1:0] o_addr,
  output logic      [DATA_W-1:0] o_wdata,
  output logic                   o_wr,
  output logic                   o_sdo,
  output logic                   o_done
);

  if (ADDR_W + 1 != `HCI_SER_HDR_BITS || ADDR_W + 1 + DATA_W != `HCI_SER_FRAME_BITS) begin : g_chk
    $error("hci_serial_port: frame layout does not match widths");
  end

  logic                          sclk_q;
  logic [`HCI_SER_CNT_W-1:0]     cnt_q;
  logic [`HCI_SER_HDR_BITS-1:0]  hdr_q;
  logic [DATA_W-1:0]             wsh_q;
  logic [DATA_W-1:0]             rsh_q;
  logic                          load_q;
  logic                          rise;
  logic                          fall;
  logic                          in_data;

  // pins are synchronous, so one flop suffices for edge detection
  assign rise    = i_sclk & ~sclk_q;
  assign fall    = ~i_sclk & sclk_q;
  assign in_data = cnt_q >= `HCI_SER_CNT_W'(`HCI_SER_HDR_BITS);

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= i_sclk;
    end
  end

  // input bits sampled on rising shift clock
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q  <= '0;
      hdr_q  <= '0;
      wsh_q  <= '0;
      o_wr   <= 1'b0;
      o_done <= 1'b0;
      load_q <= 1'b0;
    end else begin
      o_wr   <= 1'b0;
      o_done <= 1'b0;
      load_q <= 1'b0;
      if (!i_enable) begin
        cnt_q <= '0;
      end else if (rise && !o_done) begin
        cnt_q <= cnt_q + 1'b1;
        if (!in_data) begin
          hdr_q <= {hdr_q[`HCI_SER_HDR_BITS-2:0], i_sdi};
          load_q <= (cnt_q == `HCI_SER_CNT_W'(`HCI_SER_HDR_BITS - 1));
        end else begin
          wsh_q <= {wsh_q[DATA_W-2:0], i_sdi};
        end
        if (cnt_q == `HCI_SER_CNT_W'(`HCI_SER_FRAME_BITS - 1)) begin
          o_done <= 1'b1;
          o_wr   <= ~hdr_q[`HCI_SER_HDR_BITS-1];
        end
      end
    end
  end

  // read data leaves on falling shift clock, one bit at a time
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      rsh_q <= '0;
      o_sdo <= 1'b0;
    end else if (!i_enable) begin
      o_sdo <= 1'b0;
    end else if (load_q) begin
      rsh_q <= i_rdata;
    end else if (fall && in_data && hdr_q[`HCI_SER_HDR_BITS-1]) begin
      o_sdo <= rsh_q[DATA_W-1];
      rsh_q <= {rsh_q[DATA_W-2:0], 1'b0};
    end
  end

  // last bit shifts in on the edge that raises o_wr, so the shifter is whole in the cycle o_wr is high
  assign o_addr  = hdr_q[ADDR_W-1:0];
  assign o_wdata = wsh_q;

endmodule

//--- rtl/hci_host_port.sv
// Functional notes
// - a low reset pulse longer than 100 ns resets everything; host holds it that long.
// - pin control bits 1..0 set each general pin as input or output.
// - an input pin's sampled level reads back in its bit within bits 3..2.
// - an output pin drives the level held in its bit within bits 3..2.
// - open-drain low interrupt stays asserted while any unmasked indication is set.
// - parallel address bus selects the register; serial mode ties address to ground.
// - parallel data bus carries read data out and write data in.
// - serial read data shifts out on data line 0; lines 7..1 unused.
// - bus style select low chooses direction strobe, high separate strobes.
// - in direction strobe style, control high means read, low means write.
// - in separate strobe style, control is a low write strobe capturing data.
// - serial host select low picks parallel operation, high picks serial.
// - serial output updates on falling shift clock, input sampled on rising.
// - in direction strobe style, the strobe input is a low data strobe.
// - in separate strobe style, the strobe input is a low read strobe.
`timescale 1ns/100ps
`include "hci_consts.svh"

module hci_host_port #(
  parameter int GPIO_N         = `HCI_GPIO_N,
  parameter int RESET_WAIT_CYC = `HCI_RESET_WAIT_CYC
) (
  // clock and reset
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_resetn,
  // mode straps
  input  wire logic                   i_serial_host_select,
  input  wire logic                   i_bus_style_select,
  // host bus
  input  wire logic                   i_cs_n,
  input  wire logic [`HCI_ADDR_W-1:0] i_addr,
  input  wire logic                   i_data_strobe_n,
  input  wire logic                   i_rw_wr_n,
  input  wire logic [`HCI_DATA_W-1:0] i_data,
  output logic      [`HCI_DATA_W-1:0] o_data,
  output logic      [`HCI_DATA_W-1:0] o_data_oe,
  // general purpose pins
  input  wire logic [GPIO_N-1:0]      i_gpio,
  output logic      [GPIO_N-1:0]      o_gpio,
  output logic      [GPIO_N-1:0]      o_gpio_oe,
  // interrupt
  input  wire logic                   i_irq_active,
  output logic                        o_int_n,
  output logic                        o_int_n_oe,
  // status
  output logic                        o_regs_ready
);

  if (GPIO_N < 1 || GPIO_N > 2 || RESET_WAIT_CYC < 1) begin : g_chk
    $error("hci_host_port: unsupported parameter values");
  end

  localparam int WAIT_W = $clog2(RESET_WAIT_CYC + 1);

  hci_pkg::hci_state_t        state_q;
  logic [WAIT_W-1:0]          wait_q;
  logic                       cs_q;
  logic                       rd_q;
  logic [`HCI_ADDR_W-1:0]     addr_q;
  logic [`HCI_DATA_W-1:0]     wdata_q;
  logic [GPIO_N-1:0]          dir_q;
  logic [GPIO_N-1:0]          level_q;
  logic                       serial;
  logic                       strobe;
  logic                       is_read;
  logic                       par_wr;
  logic                       reg_wr;
  logic [`HCI_ADDR_W-1:0]     reg_addr;
  logic [`HCI_DATA_W-1:0]     reg_wdata;
  logic [`HCI_DATA_W-1:0]     rdata;
  logic [GPIO_N-1:0]          level_rd;
  logic                       ser_en;
  logic [`HCI_ADDR_W-1:0]     ser_addr;
  logic [`HCI_DATA_W-1:0]     ser_wdata;
  logic                       ser_wr;
  logic                       ser_sdo;
  logic                       ser_done;

  assign serial = i_serial_host_select;

  // strobe decode per bus style
  always_comb begin
    if (hci_pkg::hci_style_t'(i_bus_style_select) == hci_pkg::HCI_STYLE_DIR_STROBE) begin
      strobe  = ~i_data_strobe_n;
      is_read = i_rw_wr_n;
    end else begin
      strobe  = ~i_data_strobe_n | ~i_rw_wr_n;
      is_read = ~i_data_strobe_n;
    end
  end

  // register access is held off until the post-reset wait expires
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      wait_q       <= '0;
      o_regs_ready <= 1'b0;
    end else if (!o_regs_ready) begin
      wait_q       <= wait_q + 1'b1;
      o_regs_ready <= (wait_q == WAIT_W'(RESET_WAIT_CYC - 1));
    end
  end

  // access sequencer; one access per chip select fall
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= hci_pkg::HCI_ST_BLOCKED;
      cs_q    <= 1'b0;
      rd_q    <= 1'b0;
      addr_q  <= '0;
      wdata_q <= '0;
    end else begin
      cs_q <= ~i_cs_n;
      case (state_q)
        hci_pkg::HCI_ST_BLOCKED: begin
          // leaving test mode needs chip select high at least once
          if (i_cs_n && o_regs_ready) begin
            state_q <= hci_pkg::HCI_ST_IDLE;
          end
        end
        hci_pkg::HCI_ST_IDLE: begin
          if (!i_cs_n) begin
            state_q <= hci_pkg::HCI_ST_ARMED;
          end
        end
        hci_pkg::HCI_ST_ARMED: begin
          if (i_cs_n) begin
            state_q <= hci_pkg::HCI_ST_IDLE;
          end else if (serial) begin
            if (ser_done) begin
              state_q <= hci_pkg::HCI_ST_BLOCKED;
            end
          end else if (strobe) begin
            state_q <= hci_pkg::HCI_ST_XFER;
            rd_q    <= is_read;
            addr_q  <= i_addr;
            wdata_q <= i_data;
          end
        end
        hci_pkg::HCI_ST_XFER: begin
          if (i_cs_n) begin
            state_q <= hci_pkg::HCI_ST_IDLE;
          end else if (!strobe) begin
            state_q <= hci_pkg::HCI_ST_BLOCKED;
          end else if (!rd_q) begin
            wdata_q <= i_data;
          end
        end
        default: begin
          state_q <= hci_pkg::HCI_ST_BLOCKED;
        end
      endcase
    end
  end

  // parallel write commits when the strobe releases, after data settled
  assign par_wr = (state_q == hci_pkg::HCI_ST_XFER) && !i_cs_n && !strobe && !rd_q && !serial;
  assign ser_en = (state_q == hci_pkg::HCI_ST_ARMED) && !i_cs_n && serial;

  hci_serial_port #(
    .ADDR_W (`HCI_ADDR_W),
    .DATA_W (`HCI_DATA_W)
  ) u_serial (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .i_enable  (ser_en),
    .i_sclk    (i_data_strobe_n),
    .i_sdi     (i_rw_wr_n),
    .i_rdata   (rdata),
    .o_addr    (ser_addr),
    .o_wdata   (ser_wdata),
    .o_wr      (ser_wr),
    .o_sdo     (ser_sdo),
    .o_done    (ser_done)
  );

  assign reg_wr    = par_wr | (ser_wr & ser_en);
  assign reg_addr  = serial ? ser_addr : addr_q;
  assign reg_wdata = serial ? ser_wdata : wdata_q;

  // pin control register
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      dir_q   <= GPIO_N'(`HCI_GPC_RESET >> `HCI_GPC_DIR_LSB);
      level_q <= GPIO_N'(`HCI_GPC_RESET >> `HCI_GPC_LEVEL_LSB);
    end else if (reg_wr && reg_addr == `HCI_GPC_ADDR) begin
      dir_q   <= reg_wdata[`HCI_GPC_DIR_LSB +: GPIO_N];
      level_q <= reg_wdata[`HCI_GPC_LEVEL_LSB +: GPIO_N];
    end
  end

  // per pin: output level from register, input level read back
  for (genvar g = 0; g < GPIO_N; g++) begin : g_gpio
    assign level_rd[g] = dir_q[g] ? level_q[g] : i_gpio[g];

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
        o_gpio[g]    <= 1'b0;
        o_gpio_oe[g] <= 1'b0;
      end else begin
        o_gpio[g]    <= level_q[g];
        o_gpio_oe[g] <= dir_q[g];
      end
    end
  end

  // reserved bits and unmapped addresses read as zero
  always_comb begin
    rdata = `HCI_UNMAPPED_RDATA;
    if (reg_addr == `HCI_GPC_ADDR) begin
      rdata[`HCI_GPC_DIR_LSB +: GPIO_N]   = dir_q;
      rdata[`HCI_GPC_LEVEL_LSB +: GPIO_N] = level_rd;
    end
  end

  // data bus drive; one cycle of lag traded for flop-driven pins
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_data    <= '0;
      o_data_oe <= '0;
    end else if (serial) begin
      o_data    <= {{(`HCI_DATA_W-1){1'b0}}, ser_sdo};
      o_data_oe <= {{(`HCI_DATA_W-1){1'b0}}, ser_en};
    end else if (state_q == hci_pkg::HCI_ST_XFER && rd_q && !i_cs_n && strobe && is_read) begin
      o_data    <= rdata;
      o_data_oe <= '1;
    end else begin
      o_data    <= '0;
      o_data_oe <= '0;
    end
  end

  // open drain: only ever pulls low
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_int_n    <= 1'b0;
      o_int_n_oe <= 1'b0;
    end else begin
      o_int_n    <= 1'b0;
      o_int_n_oe <= i_irq_active;
    end
  end

endmodule

//--- bench/hci_host_port_properties.sv
`timescale 1ns/100ps
module hci_host_port_chk #(
  parameter int GPIO_N         = 2,
  parameter int RESET_WAIT_CYC = 16
) (
  // watched ports
  input wire logic              i_clk_sys,
  input wire logic              i_resetn,
  input wire logic              i_serial_host_select,
  input wire logic              i_bus_style_select,
  input wire logic              i_cs_n,
  input wire logic              i_data_strobe_n,
  input wire logic              i_rw_wr_n,
  input wire logic              i_irq_active,
  input wire logic [7:0]        o_data_oe,
  input wire logic              o_int_n,
  input wire logic              o_int_n_oe,
  input wire logic [GPIO_N-1:0] o_gpio_oe,
  input wire logic              o_regs_ready
);
  logic [31:0] cnt_q;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  // saturates so a long run never wraps
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) cnt_q <= '0;
    else if (cnt_q <= RESET_WAIT_CYC) cnt_q <= cnt_q + 32'h1;
  end
  property p_int_on; i_irq_active |=> o_int_n_oe && !o_int_n; endproperty
  a_int_on: assert property (p_int_on) else $error("int line not pulled");
  property p_int_off; !i_irq_active |=> !o_int_n_oe; endproperty
  a_int_off: assert property (p_int_off) else $error("int line not released");
  property p_oe_cs; i_cs_n |=> o_data_oe == 8'h00; endproperty
  a_oe_cs: assert property (p_oe_cs) else $error("bus driven while deselected");
  property p_ser_oe;
    $fell(i_cs_n) && $past(o_regs_ready, 2) && i_serial_host_select ##1
    (!i_cs_n && i_serial_host_select)[*2] |-> o_data_oe == 8'h01;
  endproperty
  a_ser_oe: assert property (p_ser_oe) else $error("serial out not on line 0 only");
  property p_dir_wr; (!i_serial_host_select && !i_bus_style_select && !i_rw_wr_n)[*2] |-> o_data_oe == 8'h00; endproperty
  a_dir_wr: assert property (p_dir_wr) else $error("bus driven during write");
  property p_rd_idle; (!i_serial_host_select && i_bus_style_select && i_data_strobe_n)[*2] |-> o_data_oe == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("bus driven without read strobe");
  property p_dir_hold; i_cs_n[*4] |=> $stable(o_gpio_oe); endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("pin direction changed while idle");
  property p_ready_early; cnt_q < RESET_WAIT_CYC |-> !o_regs_ready; endproperty
  a_ready_early: assert property (p_ready_early) else $error("ready too early");
  property p_ready_late; cnt_q == RESET_WAIT_CYC |-> o_regs_ready; endproperty
  a_ready_late: assert property (p_ready_late) else $error("ready too late");
endmodule

bind hci_host_port hci_host_port_chk #(.GPIO_N(GPIO_N), .RESET_WAIT_CYC(RESET_WAIT_CYC)) u_hci_host_port_chk (
  .i_clk_sys, .i_resetn, .i_serial_host_select, .i_bus_style_select, .i_cs_n, .i_data_strobe_n,
  .i_rw_wr_n, .i_irq_active, .o_data_oe, .o_int_n, .o_int_n_oe, .o_gpio_oe, .o_regs_ready);

//--- bench/hci_host_model.sv
`timescale 1ns/100ps
module hci_host_model (
  // clock and device side
  input  wire logic       i_clk_sys,
  input  wire logic [7:0] i_q,
  input  wire logic [7:0] i_q_oe,
  // host pins
  output logic            o_cs_n,
  output logic [10:0]     o_addr,
  output logic            o_ds_n,
  output logic            o_rw,
  output logic            o_ser,
  output logic            o_sty,
  output logic [7:0]      o_bus
);
  logic       h_oe;
  logic [7:0] h_d;
  logic       tog = 1'b0;
  // undriven lines must not look like held data
  always @(posedge i_clk_sys) tog <= !tog;
  assign o_bus = (i_q & i_q_oe) | (~i_q_oe & (h_oe ? h_d : (o_ser ? {7'h00, tog} : {8{tog}})));
  initial begin
    {o_cs_n, o_ds_n, o_rw} = 3'h7;
    {o_ser, o_sty, h_oe} = 3'h0;
    o_addr = 11'h000;
    h_d = 8'h00;
  end
  task automatic mode(input logic s, input logic y);
    @(negedge i_clk_sys);
    o_ser = s;
    o_sty = y;
    o_ds_n = !s;
    o_rw = !s;
    repeat (2) @(negedge i_clk_sys);
  endtask
  task automatic xfer(input logic w, input logic [10:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge i_clk_sys);
    o_cs_n = 0;
    o_addr = a;
    h_d = d;
    h_oe = w;
    @(negedge i_clk_sys);
    if (o_sty && w) o_rw = 0;
    else begin
      o_ds_n = 0;
      o_rw = !w;
    end
    repeat (3) @(negedge i_clk_sys);
    q = o_bus;
    o_ds_n = 1;
    o_rw = 1;
    @(negedge i_clk_sys);
    o_cs_n = 1;
    h_oe = 0;
    repeat (3) @(negedge i_clk_sys);
  endtask
  // shift clock idles low, four system cycles per level
  task automatic ser(input logic r, input logic [10:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [19:0] f;
    f = {r, a, d};
    @(negedge i_clk_sys);
    o_cs_n = 0;
    o_addr = 11'h000;
    for (int i = 19; i >= 0; i--) begin
      o_rw = f[i];
      repeat (4) @(negedge i_clk_sys);
      if (i < 8) q[i] = o_bus[0];
      o_ds_n = 1;
      repeat (4) @(negedge i_clk_sys);
      o_ds_n = 0;
    end
    repeat (4) @(negedge i_clk_sys);
    o_cs_n = 1;
    repeat (3) @(negedge i_clk_sys);
  endtask
endmodule

//--- bench/tb.sv
`timescale 1ns/100ps
module tb;
  logic        i_clk_sys;
  logic        i_resetn;
  logic        i_serial_host_select;
  logic        i_bus_style_select;
  logic        i_cs_n;
  logic [10:0] i_addr;
  logic        i_data_strobe_n;
  logic        i_rw_wr_n;
  logic [7:0]  i_data;
  logic [7:0]  o_data;
  logic [7:0]  o_data_oe;
  logic [1:0]  i_gpio;
  logic [1:0]  o_gpio;
  logic [1:0]  o_gpio_oe;
  logic        i_irq_active;
  logic        o_int_n;
  logic        o_int_n_oe;
  logic        o_regs_ready;
  logic [7:0]  r;
  int          fail_count;
  int          n_tests;

  initial begin
    i_clk_sys = 0;
    forever #4 i_clk_sys = !i_clk_sys;
  end

  hci_host_port #(.RESET_WAIT_CYC(16)) u_hci_host_port (
    .i_clk_sys, .i_resetn, .i_serial_host_select, .i_bus_style_select, .i_cs_n, .i_addr,
    .i_data_strobe_n, .i_rw_wr_n, .i_data, .o_data, .o_data_oe, .i_gpio, .o_gpio, .o_gpio_oe,
    .i_irq_active, .o_int_n, .o_int_n_oe, .o_regs_ready);

  hci_host_model u_hci_host_model (
    .i_clk_sys, .i_q(o_data), .i_q_oe(o_data_oe), .o_cs_n(i_cs_n), .o_addr(i_addr),
    .o_ds_n(i_data_strobe_n), .o_rw(i_rw_wr_n), .o_ser(i_serial_host_select),
    .o_sty(i_bus_style_select), .o_bus(i_data));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("tests=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wait_ready;
    int i;
    i = 0;
    while (o_regs_ready !== 1'b1 && i < 40) begin
      @(negedge i_clk_sys);
      i++;
    end
    chk({7'h00, o_regs_ready}, 8'h01);
    chk(8'(i), 8'h10);
    if (i == 40) complete_run;
    repeat (2) @(negedge i_clk_sys);
  endtask

  initial begin
    fail_count = 0;
    n_tests = 0;
    i_resetn = 0;
    i_irq_active = 0;
    i_gpio = 2'b01;
    repeat (4) @(negedge i_clk_sys);
    i_resetn = 1;
    wait_ready;
    u_hci_host_model.mode(0, 0);
    u_hci_host_model.xfer(1, 11'h006, 8'hf7, r);
    chk({4'h0, o_gpio_oe, o_gpio}, 8'h0d);
    u_hci_host_model.xfer(0, 11'h006, 8'h00, r);
    chk(r, 8'h07);
    $display("test dir_strobe done");
    u_hci_host_model.mode(0, 1);
    u_hci_host_model.xfer(1, 11'h006, 8'h0a, r);
    chk({4'h0, o_gpio_oe, o_gpio}, 8'h0a);
    u_hci_host_model.xfer(0, 11'h006, 8'h00, r);
    chk(r, 8'h0e);
    i_gpio = 2'b00;
    u_hci_host_model.xfer(0, 11'h006, 8'h00, r);
    chk(r, 8'h0a);
    $display("test rd_wr_strobe done");
    u_hci_host_model.xfer(1, 11'h7ff, 8'hff, r);
    u_hci_host_model.xfer(0, 11'h7ff, 8'h00, r);
    chk(r, 8'h00);
    u_hci_host_model.xfer(0, 11'h006, 8'h00, r);
    chk(r, 8'h0a);
    $display("test unmapped done");
    u_hci_host_model.mode(1, 0);
    u_hci_host_model.ser(1, 11'h006, 8'h00, r);
    chk(r, 8'h0a);
    u_hci_host_model.ser(0, 11'h006, 8'h03, r);
    chk({4'h0, o_gpio_oe, o_gpio}, 8'h0c);
    $display("test serial done");
    u_hci_host_model.mode(0, 0);
    i_irq_active = 1;
    repeat (2) @(negedge i_clk_sys);
    chk({6'h00, o_int_n_oe, o_int_n}, 8'h02);
    i_irq_active = 0;
    repeat (2) @(negedge i_clk_sys);
    chk({6'h00, o_int_n_oe, o_int_n}, 8'h00);
    $display("test interrupt done");
    i_resetn = 0;
    repeat (13) @(negedge i_clk_sys);
    chk({5'h00, o_gpio_oe, o_regs_ready}, 8'h00);
    i_resetn = 1;
    wait_ready;
    u_hci_host_model.xfer(0, 11'h006, 8'h00, r);
    chk(r, 8'h00);
    $display("test reset done");
    complete_run;
  end
endmodule
